// file: rtl/pmc_pkg.sv
package pmc_pkg;

  // Object dictionary indices handled by this block.
  localparam logic [15:0] IDX_RX_MAP    = 16'h1600;
  localparam logic [15:0] IDX_TX_MAP    = 16'h1A00;
  localparam logic [15:0] IDX_RX_ASSIGN = 16'h1C12;
  localparam logic [15:0] IDX_TX_ASSIGN = 16'h1C13;
  localparam logic [15:0] IDX_RX_FIX_LO = 16'h1701;
  localparam logic [15:0] IDX_RX_FIX_HI = 16'h1705;
  localparam logic [15:0] IDX_TX_FIX_LO = 16'h1B01;
  localparam logic [15:0] IDX_TX_FIX_HI = 16'h1B04;

  // Sub-index layout.
  localparam logic [7:0]  SUB_COUNT     = 8'h00;
  localparam logic [7:0]  SUB_SELECT    = 8'h01;
  localparam logic [7:0]  MAP_MAX_ENTRY = 8'h0A;
  localparam logic [7:0]  MAP_MAX_BYTES = 8'h28;

  // Entry field positions: index, sub-index, bit length.
  localparam int ENT_IDX_LSB = 16;
  localparam int ENT_SUB_LSB = 8;
  localparam int ENT_LEN_LSB = 0;

  // Bit length codes of a mapping entry.
  localparam logic [7:0]  LEN_8  = 8'h08;
  localparam logic [7:0]  LEN_16 = 8'h10;
  localparam logic [7:0]  LEN_32 = 8'h20;

  // Fieldbus state machine code for pre-operational.
  localparam logic [3:0]  ESM_PREOP = 4'h2;

  // Service-data abort codes.
  localparam logic [31:0] ABORT_NONE    = 32'h0000_0000;
  localparam logic [31:0] ABORT_NO_OBJ  = 32'h0602_0000;
  localparam logic [31:0] ABORT_NO_SUB  = 32'h0609_0011;
  localparam logic [31:0] ABORT_VALUE   = 32'h0609_0030;
  localparam logic [31:0] ABORT_MAP_LEN = 32'h0604_0042;
  localparam logic [31:0] ABORT_PARAM   = 32'h0604_0043;
  localparam logic [31:0] ABORT_STATE   = 32'h0800_0022;

  // Ten mapping entries of one configurable mapping.
  typedef logic [9:0][31:0] pmc_map_t;

  // Power-on default contents of the configurable mappings.
  localparam pmc_map_t RX_MAP_RST = {
    32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
    32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
    32'h60FF_0020, 32'h6040_0010};
  localparam pmc_map_t TX_MAP_RST = {
    32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h60FD_0020,
    32'h603F_0010, 32'h60BC_0020, 32'h60BA_0020, 32'h60B9_0010,
    32'h6064_0020, 32'h6041_0010};
  localparam logic [7:0]  RX_CNT_RST   = 8'h02;
  localparam logic [7:0]  TX_CNT_RST   = 8'h07;
  localparam logic [7:0]  RX_BYTES_RST = 8'h06;
  localparam logic [7:0]  TX_BYTES_RST = 8'h16;
  localparam logic [7:0]  ASSIGN_EN_RST = 8'h01;

  // Service-data request from the mailbox side.
  typedef struct packed {
    logic        wr;
    logic [15:0] index;
    logic [7:0]  sub;
    logic [31:0] data;
  } pmc_req_t;

  // Service-data response; data holds the abort code when abort is set.
  typedef struct packed {
    logic        abort;
    logic [31:0] data;
  } pmc_rsp_t;

endpackage

// file: rtl/pmc_len_sum.sv
// Sums the process data bytes of the first count entries of a mapping
// and flags whether the count, the byte total and the used entries' length codes are legal.
module pmc_len_sum
  import pmc_pkg::*;
(
  // Mapping under test.
  input  wire pmc_pkg::pmc_map_t i_map,
  input  wire logic [7:0]        i_count,
  // Result.
  output logic       [7:0]       o_bytes,
  output logic                   o_ok
);
  import pmc_pkg::*;

  // Decode each length code to bytes and accumulate the used entries.
  always_comb begin
    logic [7:0] len;
    logic       bad;
    len     = 8'h00;
    bad     = 1'b0;
    o_bytes = 8'h00;
    for (int i = 0; i < 10; i++) begin
      len = i_map[i][ENT_LEN_LSB +: 8];
      if (8'(i) < i_count) begin
        unique case (len)
          LEN_8:   o_bytes = o_bytes + 8'h01;
          LEN_16:  o_bytes = o_bytes + 8'h02;
          LEN_32:  o_bytes = o_bytes + 8'h04;
          default: bad = 1'b1;
        endcase
      end
    end
    o_ok = !bad && (i_count <= MAP_MAX_ENTRY)
           && (o_bytes <= MAP_MAX_BYTES);
  end

endmodule // pmc_len_sum

// file: rtl/pmc_map_cfg.sv
// What this block does
// - One configurable receive and transmit mapping, ten entries, forty bytes.
// - Receive mapping defaults to control word then target speed.
// - Transmit mapping defaults to seven status and feedback objects in order.
// - Receive assignment sub-index one picks the active receive mapping.
// - Transmit assignment sub-index one picks the active transmit mapping.
// - Sub-index zero counts entries; sub-indices one to N hold them.
// - Entry holds index in 31:16, sub-index 15:8, bit length 7:0.
// - Length codes 08h, 10h, 20h mean 8, 16, 32 bits.
// - Mapping and assignment writes outside pre-operational are aborted.
// - Every mapping and assignment object returns to defaults at power-on.
// - Receive assignment accepts only 1600 or 1701 to 1705.
// - Transmit assignment accepts only 1A00 or 1B01 to 1B04.
// - Every service-data request gets exactly one matching response.
// - Cycle event comes from SYNC0 in clock mode, else sync manager.
// - Five fixed receive and four fixed transmit mappings are selectable.
module pmc_map_cfg
(
  // Clock and reset.
  input  wire logic               i_clk,
  input  wire logic               i_rst,
  // Service-data request, taken in the cycle it is valid.
  input  wire logic               i_req_valid,
  input  wire pmc_pkg::pmc_req_t  i_req,
  // Fieldbus state machine state.
  input  wire logic [3:0]         i_esm_state,
  // Synchronisation sources.
  input  wire logic               i_dc_mode,
  input  wire logic               i_sync0,
  input  wire logic               i_sm_event,
  // Service-data response.
  output logic                    o_rsp_valid,
  output pmc_pkg::pmc_rsp_t       o_rsp,
  // Active mapping selection.
  output logic [15:0]             o_rx_sel,
  output logic                    o_rx_en,
  output logic [15:0]             o_tx_sel,
  output logic                    o_tx_en,
  // Configurable mapping contents.
  output pmc_pkg::pmc_map_t       o_rx_map,
  output logic [7:0]              o_rx_cnt,
  output logic [7:0]              o_rx_bytes,
  output pmc_pkg::pmc_map_t       o_tx_map,
  output logic [7:0]              o_tx_cnt,
  output logic [7:0]              o_tx_bytes,
  // Process data cycle pulse.
  output logic                    o_cycle
);
  import pmc_pkg::*;

  typedef struct packed {
    pmc_map_t    rx_map;
    logic [7:0]  rx_cnt;
    logic [7:0]  rx_bytes;
    pmc_map_t    tx_map;
    logic [7:0]  tx_cnt;
    logic [7:0]  tx_bytes;
    logic [15:0] rx_sel;
    logic [7:0]  rx_en;
    logic [15:0] tx_sel;
    logic [7:0]  tx_en;
    logic        rsp_valid;
    pmc_rsp_t    rsp;
    logic        sync_meta;
    logic        sync_sync;
    logic        sync_prev;
    logic        cyc;
  } pmc_state_t;

  localparam pmc_state_t ST_RST = '{
    rx_map: RX_MAP_RST, rx_cnt: RX_CNT_RST, rx_bytes: RX_BYTES_RST,
    tx_map: TX_MAP_RST, tx_cnt: TX_CNT_RST, tx_bytes: TX_BYTES_RST,
    rx_sel: IDX_RX_MAP, rx_en: ASSIGN_EN_RST,
    tx_sel: IDX_TX_MAP, tx_en: ASSIGN_EN_RST,
    rsp_valid: 1'b0, rsp: '0,
    sync_meta: 1'b0, sync_sync: 1'b0, sync_prev: 1'b0, cyc: 1'b0};

  pmc_state_t st_reg;
  pmc_state_t st_next;

  logic        rx_cnt_wr;
  logic        tx_cnt_wr;
  logic [7:0]  rx_cnt_try;
  logic [7:0]  tx_cnt_try;
  logic [7:0]  rx_bytes_try;
  logic [7:0]  tx_bytes_try;
  logic        rx_ok;
  logic        tx_ok;

  // Legal selection for each assignment object.
  function automatic logic rx_sel_legal(input logic [15:0] v);
    return (v == IDX_RX_MAP)
           || (v >= IDX_RX_FIX_LO && v <= IDX_RX_FIX_HI);
  endfunction

  function automatic logic tx_sel_legal(input logic [15:0] v);
    return (v == IDX_TX_MAP)
           || (v >= IDX_TX_FIX_LO && v <= IDX_TX_FIX_HI);
  endfunction

  // Length code check of one entry.
  function automatic logic len_legal(input logic [31:0] e);
    logic [7:0] c;
    c = e[ENT_LEN_LSB +: 8];
    return (c == LEN_8) || (c == LEN_16) || (c == LEN_32);
  endfunction

  // Abort code of a write to a configurable mapping.
  function automatic logic [31:0] map_wr_code(
    input logic [7:0]  cnt,
    input logic [7:0]  en,
    input logic [7:0]  sub,
    input logic [31:0] data,
    input logic        ok
  );
    logic [31:0] c;
    c = ABORT_NONE;
    if (sub > MAP_MAX_ENTRY) begin
      c = ABORT_NO_SUB;
    end else if (en != 8'h00) begin
      c = ABORT_PARAM;
    end else if (sub == SUB_COUNT) begin
      if (data[31:8] != 24'h00_0000 || !ok) begin
        c = ABORT_MAP_LEN;
      end
    end else if (cnt != 8'h00) begin
      c = ABORT_PARAM;
    end else if (!len_legal(data)) begin
      c = ABORT_MAP_LEN;
    end
    return c;
  endfunction

  // Read data of a configurable mapping sub-index.
  function automatic logic [31:0] map_rd(
    input pmc_map_t   m,
    input logic [7:0] cnt,
    input logic [7:0] sub
  );
    logic [3:0] k;
    k = sub[3:0] - 4'h1;
    return (sub == SUB_COUNT) ? {24'h00_0000, cnt} : m[k];
  endfunction

  // Candidate count for the legality check: the written one or the stored one.
  assign rx_cnt_wr  = i_req_valid && i_req.wr
                      && i_req.index == IDX_RX_MAP && i_req.sub == SUB_COUNT;
  assign tx_cnt_wr  = i_req_valid && i_req.wr
                      && i_req.index == IDX_TX_MAP && i_req.sub == SUB_COUNT;
  assign rx_cnt_try = rx_cnt_wr ? i_req.data[7:0] : st_reg.rx_cnt;
  assign tx_cnt_try = tx_cnt_wr ? i_req.data[7:0] : st_reg.tx_cnt;

  pmc_len_sum u_rx_len (
    .i_map   (st_reg.rx_map),
    .i_count (rx_cnt_try),
    .o_bytes (rx_bytes_try),
    .o_ok    (rx_ok)
  );

  pmc_len_sum u_tx_len (
    .i_map   (st_reg.tx_map),
    .i_count (tx_cnt_try),
    .o_bytes (tx_bytes_try),
    .o_ok    (tx_ok)
  );

  // Next state: request decode, object updates and cycle event.
  always_comb begin
    logic [31:0] code;
    logic [31:0] rdat;
    logic [3:0]  k;
    code = ABORT_NONE;
    rdat = 32'h0000_0000;
    k    = i_req.sub[3:0] - 4'h1;
    st_next = st_reg;
    st_next.rsp_valid = 1'b0;
    // Only the second stage reads the first synchroniser flop.
    st_next.sync_meta = i_sync0;
    st_next.sync_sync = st_reg.sync_meta;
    st_next.sync_prev = st_reg.sync_sync;
    st_next.cyc = i_dc_mode ? (st_reg.sync_sync && !st_reg.sync_prev)
                            : i_sm_event;
    if (i_req_valid) begin
      unique case (i_req.index)
        IDX_RX_MAP: begin
          if (!i_req.wr) begin
            code = (i_req.sub > MAP_MAX_ENTRY) ? ABORT_NO_SUB : ABORT_NONE;
            rdat = map_rd(st_reg.rx_map, st_reg.rx_cnt, i_req.sub);
          end else begin
            code = map_wr_code(st_reg.rx_cnt, st_reg.rx_en, i_req.sub,
                               i_req.data, rx_ok);
          end
        end
        IDX_TX_MAP: begin
          if (!i_req.wr) begin
            code = (i_req.sub > MAP_MAX_ENTRY) ? ABORT_NO_SUB : ABORT_NONE;
            rdat = map_rd(st_reg.tx_map, st_reg.tx_cnt, i_req.sub);
          end else begin
            code = map_wr_code(st_reg.tx_cnt, st_reg.tx_en, i_req.sub,
                               i_req.data, tx_ok);
          end
        end
        IDX_RX_ASSIGN, IDX_TX_ASSIGN: begin
          if (i_req.sub > SUB_SELECT) begin
            code = ABORT_NO_SUB;
          end else if (!i_req.wr) begin
            if (i_req.index == IDX_RX_ASSIGN) begin
              rdat = (i_req.sub == SUB_COUNT) ? {24'h00_0000, st_reg.rx_en}
                                              : {16'h0000, st_reg.rx_sel};
            end else begin
              rdat = (i_req.sub == SUB_COUNT) ? {24'h00_0000, st_reg.tx_en}
                                              : {16'h0000, st_reg.tx_sel};
            end
          end else if (i_req.sub == SUB_COUNT) begin
            if (i_req.data > 32'h0000_0001) begin
              code = ABORT_VALUE;
            end
          end else if (i_req.data[31:16] != 16'h0000) begin
            code = ABORT_VALUE;
          end else if (i_req.index == IDX_RX_ASSIGN) begin
            if (!rx_sel_legal(i_req.data[15:0])) begin
              code = ABORT_VALUE;
            end else if (st_reg.rx_en != 8'h00) begin
              code = ABORT_PARAM;
            end
          end else begin
            if (!tx_sel_legal(i_req.data[15:0])) begin
              code = ABORT_VALUE;
            end else if (st_reg.tx_en != 8'h00) begin
              code = ABORT_PARAM;
            end
          end
        end
        default: begin
          code = ABORT_NO_OBJ;
        end
      endcase
      // State gate takes priority over every other write check except the missing-object abort.
      if (i_req.wr && i_esm_state != ESM_PREOP
          && code != ABORT_NO_OBJ) begin
        code = ABORT_STATE;
      end
      // Commit an accepted write.
      if (i_req.wr && code == ABORT_NONE) begin
        unique case (i_req.index)
          IDX_RX_MAP: begin
            if (i_req.sub == SUB_COUNT) begin
              st_next.rx_cnt   = i_req.data[7:0];
              st_next.rx_bytes = rx_bytes_try;
            end else begin
              st_next.rx_map[k] = i_req.data;
            end
          end
          IDX_TX_MAP: begin
            if (i_req.sub == SUB_COUNT) begin
              st_next.tx_cnt   = i_req.data[7:0];
              st_next.tx_bytes = tx_bytes_try;
            end else begin
              st_next.tx_map[k] = i_req.data;
            end
          end
          IDX_RX_ASSIGN: begin
            if (i_req.sub == SUB_COUNT) begin
              st_next.rx_en = i_req.data[7:0];
            end else begin
              st_next.rx_sel = i_req.data[15:0];
            end
          end
          default: begin
            if (i_req.sub == SUB_COUNT) begin
              st_next.tx_en = i_req.data[7:0];
            end else begin
              st_next.tx_sel = i_req.data[15:0];
            end
          end
        endcase
      end
      st_next.rsp_valid  = 1'b1;
      st_next.rsp.abort  = (code != ABORT_NONE);
      st_next.rsp.data   = (code != ABORT_NONE) ? code
                           : (i_req.wr ? 32'h0000_0000 : rdat);
    end
  end

  // State register; reset restores every power-on default.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_reg <= ST_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs come straight from the state register.
  assign o_rsp_valid = st_reg.rsp_valid;
  assign o_rsp       = st_reg.rsp;
  assign o_rx_sel    = st_reg.rx_sel;
  assign o_rx_en     = (st_reg.rx_en != 8'h00);
  assign o_tx_sel    = st_reg.tx_sel;
  assign o_tx_en     = (st_reg.tx_en != 8'h00);
  assign o_rx_map    = st_reg.rx_map;
  assign o_rx_cnt    = st_reg.rx_cnt;
  assign o_rx_bytes  = st_reg.rx_bytes;
  assign o_tx_map    = st_reg.tx_map;
  assign o_tx_cnt    = st_reg.tx_cnt;
  assign o_tx_bytes  = st_reg.tx_bytes;
  assign o_cycle     = st_reg.cyc;

  // Checks on the configuration behaviour.
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  sequence s_wr_busy;
    i_req_valid && i_req.wr && i_esm_state != ESM_PREOP
    && (i_req.index == IDX_RX_MAP || i_req.index == IDX_TX_MAP
        || i_req.index == IDX_RX_ASSIGN || i_req.index == IDX_TX_ASSIGN);
  endsequence
  sequence s_rx_cnt_set;
    i_req_valid && i_req.wr && i_req.index == IDX_RX_MAP
    && i_req.sub == SUB_COUNT;
  endsequence
  sequence s_ok_rsp;
    o_rsp_valid && !o_rsp.abort;
  endsequence

  chk_rsp_follows: assert property (
    i_req_valid |=> o_rsp_valid)
    else $error("request without response");
  chk_rsp_only_req: assert property (
    !i_req_valid |=> !o_rsp_valid)
    else $error("response without request");
  chk_state_abort: assert property (
    s_wr_busy |=> o_rsp.abort && o_rsp.data == ABORT_STATE)
    else $error("write outside pre-operational not aborted");
  chk_rx_sel_ok: assert property (
    rx_sel_legal(o_rx_sel))
    else $error("illegal receive selection stored");
  chk_tx_sel_ok: assert property (
    tx_sel_legal(o_tx_sel))
    else $error("illegal transmit selection stored");
  chk_map_limits: assert property (
    o_rx_cnt <= MAP_MAX_ENTRY && o_tx_cnt <= MAP_MAX_ENTRY
    && o_rx_bytes <= MAP_MAX_BYTES && o_tx_bytes <= MAP_MAX_BYTES)
    else $error("mapping exceeds entry or byte limit");
  chk_count_store: assert property (
    (s_rx_cnt_set ##1 s_ok_rsp) |-> o_rx_cnt == $past(i_req.data[7:0]))
    else $error("accepted count not stored");
  chk_dc_cycle: assert property (
    i_dc_mode && st_reg.sync_sync && !st_reg.sync_prev |=> o_cycle)
    else $error("SYNC0 edge gave no cycle pulse");
  chk_entry_code: assert property (
    i_req_valid && i_req.wr && i_req.sub != SUB_COUNT
    && (i_req.index == IDX_RX_MAP || i_req.index == IDX_TX_MAP)
    && !len_legal(i_req.data) |=> o_rsp.abort)
    else $error("bad length code accepted");
  chk_rst_default: assert property (disable iff (1'b0)
    i_rst |=> o_rx_map == RX_MAP_RST && o_tx_map == TX_MAP_RST
              && o_rx_sel == IDX_RX_MAP && o_tx_sel == IDX_TX_MAP)
    else $error("defaults missing after reset");

endmodule // pmc_map_cfg

// file: verif/pmc_master_model.sv
// Behavioural fieldbus master that issues service-data requests and notes
// the response it expects for each one.
module pmc_master_model
  import pmc_pkg::*;
(
  // Clock.
  input  wire logic          i_clk,
  // Request towards the device.
  output logic               o_req_valid,
  output pmc_pkg::pmc_req_t  o_req
);
  timeunit 1ns;
  timeprecision 1ps;

  // Responses the device still owes, oldest first.
  pmc_rsp_t exp_q[$];

  // Nothing is requested before the bench releases reset.
  initial begin
    o_req_valid = 1'h0;
    o_req       = '0;
  end

  // Holds one request across one edge; the caller stands just past an edge.
  task automatic send(input logic wr, input logic [15:0] idx,
                      input logic [7:0] sub, input logic [31:0] data,
                      input logic ab, input logic [31:0] exp);
    exp_q.push_back({ab, exp});
    o_req_valid = 1'h1;
    o_req       = {wr, idx, sub, data};
    @(posedge i_clk);
    #1;
  endtask

  // Released lines show a changed pattern so stale values cannot help.
  task automatic idle();
    o_req_valid = 1'h0;
    o_req       = ~o_req;
    @(posedge i_clk);
    #1;
  endtask

  // Rewrites one configurable mapping in the required order.
  task automatic reconfig(input logic [15:0] asg, input logic [15:0] map,
                          input pmc_map_t ent, input int n);
    send(1'h1, asg, 8'h00, 32'h0, 1'h0, 32'h0);
    send(1'h1, map, 8'h00, 32'h0, 1'h0, 32'h0);
    for (int i = 0; i < n; i++) begin
      send(1'h1, map, 8'(i + 1), ent[i], 1'h0, 32'h0);
    end
    send(1'h1, map, 8'h00, 32'(n), 1'h0, 32'h0);
    send(1'h1, asg, 8'h00, 32'h1, 1'h0, 32'h0);
  endtask
endmodule  // pmc_master_model

// file: verif/tb_pdo_mapping_config.sv
// Self-checking bench for the mapping configuration block.
module tb_pdo_mapping_config
  import pmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        i_clk, i_rst, i_req_valid, i_dc_mode, i_sync0, i_sm_event;
  pmc_req_t    i_req;
  logic [3:0]  i_esm_state;
  logic        o_rsp_valid, o_rx_en, o_tx_en, o_cycle;
  pmc_rsp_t    o_rsp, exp_r;
  logic [15:0] o_rx_sel, o_tx_sel;
  pmc_map_t    o_rx_map, o_tx_map, ent;
  logic [7:0]  o_rx_cnt, o_rx_bytes, o_tx_cnt, o_tx_bytes, eb;
  int          fails, check_count, cycles, n;

  pmc_map_cfg uut (
    .i_clk(i_clk), .i_rst(i_rst), .i_req_valid(i_req_valid), .i_req(i_req),
    .i_esm_state(i_esm_state), .i_dc_mode(i_dc_mode), .i_sync0(i_sync0),
    .i_sm_event(i_sm_event), .o_rsp_valid(o_rsp_valid), .o_rsp(o_rsp),
    .o_rx_sel(o_rx_sel), .o_rx_en(o_rx_en), .o_tx_sel(o_tx_sel),
    .o_tx_en(o_tx_en), .o_rx_map(o_rx_map), .o_rx_cnt(o_rx_cnt),
    .o_rx_bytes(o_rx_bytes), .o_tx_map(o_tx_map), .o_tx_cnt(o_tx_cnt),
    .o_tx_bytes(o_tx_bytes), .o_cycle(o_cycle));

  pmc_master_model master (
    .i_clk(i_clk), .o_req_valid(i_req_valid), .o_req(i_req));

  // Clock of 20 ns period.
  always #10 i_clk = ~i_clk;

  // Compares one value and counts the outcome.
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Each response is matched against the oldest noted expectation.
  always @(posedge i_clk) begin
    #2;
    if (o_rsp_valid === 1'h1) begin
      if (master.exp_q.size() == 0) chk("extra response", 32'h0, 32'h1);
      else begin
        exp_r = master.exp_q.pop_front();
        chk("rsp abort", {31'h0, exp_r.abort}, {31'h0, o_rsp.abort});
        chk("rsp data", exp_r.data, o_rsp.data);
      end
    end
  end

  // Cuts a hang short.
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      conclude();
    end
  end

  // Holds reset for four cycles and releases it just past an edge.
  task automatic do_reset();
    i_rst = 1'h1;
    repeat (4) @(posedge i_clk);
    #1;
    i_rst = 1'h0;
  endtask

  // Checks power-on contents at the ports and through reads.
  task automatic defaults();
    logic [31:0] tx_d [7];
    tx_d = '{32'h6041_0010, 32'h6064_0020, 32'h60B9_0010, 32'h60BA_0020,
             32'h60BC_0020, 32'h603F_0010, 32'h60FD_0020};
    chk("rx entry 1", 32'h6040_0010, o_rx_map[0]);
    chk("rx entry 2", 32'h60FF_0020, o_rx_map[1]);
    chk("rx count", 32'h2, {24'h0, o_rx_cnt});
    chk("rx bytes", 32'h6, {24'h0, o_rx_bytes});
    chk("tx count", 32'h7, {24'h0, o_tx_cnt});
    chk("tx bytes", 32'h16, {24'h0, o_tx_bytes});
    chk("sel", 32'h1600_1A00, {o_rx_sel, o_tx_sel});
    chk("en", 32'h3, {30'h0, o_rx_en, o_tx_en});
    for (int i = 0; i < 7; i++) begin
      chk("tx entry", tx_d[i], o_tx_map[i]);
      master.send(1'h0, IDX_TX_MAP, 8'(i + 1), $urandom, 1'h0, tx_d[i]);
    end
    master.idle();
  endtask

  // Fills n random entries with legal length codes and sums their bytes.
  task automatic gen(input int cnt);
    logic [7:0] code;
    ent = '0;
    eb  = 8'h00;
    for (int i = 0; i < cnt; i++) begin
      code   = 8'h08 << ($urandom % 3);
      ent[i] = {16'($urandom), 8'($urandom), code};
      eb     = eb + (code >> 3);
    end
  endtask

  // Writes one selection and checks that only legal ones are taken.
  task automatic sel_try(input logic [15:0] asg, input logic [15:0] v,
                         input logic ok);
    logic [15:0] prev;
    prev = (asg == IDX_RX_ASSIGN) ? o_rx_sel : o_tx_sel;
    master.send(1'h1, asg, SUB_SELECT, {16'h0, v}, !ok,
                ok ? 32'h0 : ABORT_VALUE);
    chk("selection", {16'h0, ok ? v : prev},
        {16'h0, (asg == IDX_RX_ASSIGN) ? o_rx_sel : o_tx_sel});
  endtask

  // Measures the cycle pulse delay after a sync source fires.
  task automatic sync_lat(input logic dc, input logic pin, input int exp_n);
    int got;
    got = 0;
    i_dc_mode = dc;
    repeat (4) @(posedge i_clk);
    #1;
    if (pin) i_sync0 = 1'h1;
    else i_sm_event = 1'h1;
    for (int k = 1; k <= 6 && got == 0; k++) begin
      @(posedge i_clk);
      #1;
      i_sm_event = 1'h0;
      if (o_cycle === 1'h1) got = k;
    end
    i_sync0 = 1'h0;
    chk("cycle delay", 32'(exp_n), 32'(got));
  endtask

  // Main sequence.
  initial begin
    i_clk       = 1'h0;
    i_rst       = 1'h1;
    i_esm_state = ESM_PREOP;
    i_dc_mode   = 1'h0;
    i_sync0     = 1'h0;
    i_sm_event  = 1'h0;
    fails       = 0;
    check_count = 0;
    cycles      = 0;
    void'($urandom(65));
    do_reset();
    defaults();
    $display("test defaults done");
    i_esm_state = 4'h8;
    master.send(1'h1, IDX_RX_ASSIGN, 8'h00, 32'h0, 1'h1, ABORT_STATE);
    master.send(1'h1, IDX_TX_ASSIGN, 8'h01, 32'h1B01, 1'h1, ABORT_STATE);
    master.send(1'h1, IDX_RX_MAP, 8'h00, 32'h0, 1'h1, ABORT_STATE);
    master.send(1'h1, IDX_TX_MAP, 8'h00, 32'h0, 1'h1, ABORT_STATE);
    master.send(1'h0, IDX_RX_MAP, 8'h00, $urandom, 1'h0, 32'h2);
    master.idle();
    chk("state kept", 32'h0207, {o_rx_cnt, o_tx_cnt});
    $display("test state done");
    i_esm_state = ESM_PREOP;
    master.send(1'h1, {4'h5, 12'($urandom)}, 8'h00, 32'h0, 1'h1,
                ABORT_NO_OBJ);
    master.send(1'h1, IDX_RX_MAP, 8'h00, 32'h0, 1'h1, ABORT_PARAM);
    master.send(1'h1, IDX_RX_ASSIGN, 8'h00, 32'h0, 1'h0, 32'h0);
    master.send(1'h1, IDX_RX_ASSIGN, 8'h00, 32'h2, 1'h1, ABORT_VALUE);
    master.send(1'h1, IDX_RX_MAP, 8'h01, 32'h6040_0010, 1'h1,
                ABORT_PARAM);
    master.send(1'h1, IDX_RX_MAP, 8'h00, 32'h0, 1'h0, 32'h0);
    master.send(1'h1, IDX_RX_MAP, 8'h01, 32'h6040_0018, 1'h1, ABORT_MAP_LEN);
    master.send(1'h1, IDX_RX_MAP, 8'h0B, 32'h6040_0010, 1'h1, ABORT_NO_SUB);
    master.send(1'h1, IDX_RX_MAP, 8'h00, 32'h0B, 1'h1, ABORT_MAP_LEN);
    master.send(1'h1, IDX_RX_MAP, 8'h00, 32'h3, 1'h1, ABORT_MAP_LEN);
    master.send(1'h1, IDX_RX_MAP, 8'h00, 32'h100, 1'h1, ABORT_MAP_LEN);
    for (int i = 0; i < 8; i++) begin
      sel_try(IDX_RX_ASSIGN, 16'h1700 + 16'(i), i >= 1 && i <= 5);
    end
    sel_try(IDX_RX_ASSIGN, {4'h3, 12'($urandom)}, 1'h0);
    sel_try(IDX_RX_ASSIGN, IDX_RX_MAP, 1'h1);
    master.send(1'h1, IDX_TX_ASSIGN, 8'h01, 32'h1B01, 1'h1, ABORT_PARAM);
    master.send(1'h1, IDX_TX_ASSIGN, 8'h00, 32'h0, 1'h0, 32'h0);
    for (int i = 0; i < 8; i++) begin
      sel_try(IDX_TX_ASSIGN, 16'h1B00 + 16'(i), i >= 1 && i <= 4);
    end
    sel_try(IDX_TX_ASSIGN, IDX_RX_MAP, 1'h0);
    sel_try(IDX_TX_ASSIGN, IDX_TX_MAP, 1'h1);
    master.send(1'h0, IDX_TX_ASSIGN, 8'h01, $urandom, 1'h0, 32'h1A00);
    master.send(1'h1, IDX_TX_ASSIGN, 8'h02, 32'h0, 1'h1, ABORT_NO_SUB);
    $display("test refusals done");
    gen(10);
    master.reconfig(IDX_RX_ASSIGN, IDX_RX_MAP, ent, 10);
    master.send(1'h0, IDX_RX_MAP, 8'h0A, $urandom, 1'h0, ent[9]);
    master.send(1'h0, IDX_RX_ASSIGN, 8'h01, $urandom, 1'h0, 32'h1600);
    master.send(1'h0, IDX_RX_ASSIGN, 8'h00, $urandom, 1'h0, 32'h1);
    master.idle();
    for (int i = 0; i < 10; i++) chk("rx entry", ent[i], o_rx_map[i]);
    chk("rx count", 32'h0A, {24'h0, o_rx_cnt});
    chk("rx bytes", {24'h0, eb}, {24'h0, o_rx_bytes});
    chk("rx en", 32'h1, {31'h0, o_rx_en});
    n = 1 + ($urandom % 10);
    gen(n);
    master.reconfig(IDX_TX_ASSIGN, IDX_TX_MAP, ent, n);
    master.idle();
    for (int i = 0; i < n; i++) chk("tx entry", ent[i], o_tx_map[i]);
    chk("tx count", 32'(n), {24'h0, o_tx_cnt});
    chk("tx bytes", {24'h0, eb}, {24'h0, o_tx_bytes});
    chk("tx en", 32'h1, {31'h0, o_tx_en});
    $display("test reconfig done");
    do_reset();
    defaults();
    $display("test second reset done");
    sync_lat(1'h0, 1'h0, 1);
    sync_lat(1'h0, 1'h1, 0);
    sync_lat(1'h1, 1'h1, 3);
    sync_lat(1'h1, 1'h0, 0);
    $display("test sync done");
    chk("pending responses", 32'h0, 32'(master.exp_q.size()));
    conclude();
  end
endmodule  // tb_pdo_mapping_config
